// file: pkg/uart_irq_enable_defs.vh
/*
 * Constants for the per-channel interrupt mask, feature and
 * flow-character registers and the chip-wide FIFO ready summary.
 * Assumes an 8-bit parallel register port addressed by a channel
 * select and a three-bit register address.
 */
`ifndef UART_IRQ_ENABLE_DEFS_VH
`define UART_IRQ_ENABLE_DEFS_VH

// ==============================================
// Register addresses
`define ADDR_HOLD        3'h0
`define ADDR_MASK        3'h1
`define ADDR_SOURCE      3'h2
`define ADDR_FEATURE     3'h2
`define ADDR_LSTAT       3'h5
`define ADDR_MSTAT       3'h6
`define ADDR_RESUME1     3'h4
`define ADDR_RESUME2     3'h5
`define ADDR_PAUSE1      3'h6
`define ADDR_PAUSE2      3'h7
`define LCR_ENH_KEY      8'hBF
`define LCR_DIV_BIT      7

// ==============================================
// Reset values
`define MASK_RST         8'h00
`define FEATURE_RST      8'h00
`define CHAR_RST         8'h00

// ==============================================
// Field positions
`define MB_RX            0
`define MB_TX            1
`define MB_LINE          2
`define MB_MODEM         3
`define MB_SLEEP         4
`define MB_PAUSE         5
`define MB_RTS           6
`define MB_CTS           7
`define FB_ENH           4
`define FB_SPECIAL       5
`define FB_AUTO_RTS      6
`define FB_AUTO_CTS      7

// ==============================================
// Source register codes, bits 5:0
`define SRC_LINE         6'h06
`define SRC_RX           6'h04
`define SRC_TX           6'h02
`define SRC_MODEM        6'h00
`define SRC_PAUSE        6'h10
`define SRC_FLOW         6'h20
`define SRC_NONE         6'h01

`endif

// file: src/chan_irq_qual.v
/*
 * Interrupt qualification for one channel: sticky event flags,
 * enable gating and priority coding of the source register.
 * Assumes all status inputs are synchronous to clk and that the
 * read and write pulses last one cycle.
 */
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_enable_defs.vh"

module chan_irq_qual (
	input  wire       clk,
	input  wire       rst_b,
	input  wire [7:0] mask,
	input  wire [7:0] feat,
	input  wire       fifo_en,
	input  wire       rx_nonempty,
	input  wire       rx_at_trig,
	input  wire       thr_empty,
	input  wire       tx_below_trig,
	input  wire       overrun_evt,
	input  wire [2:0] head_err,
	input  wire       modem_any,
	input  wire       pause_evt,
	input  wire       resume_evt,
	input  wire       rts_out,
	input  wire       cts_in,
	input  wire       isr_rd,
	input  wire       lsr_rd,
	input  wire       msr_rd,
	input  wire       thr_wr,
	output wire       irq_req,
	output reg  [7:0] isr_val,
	output wire       overrun_flag
);

	// ==============================================
	// Flags
	reg  tx_prev_ff;
	reg  mask_tx_prev_ff;
	reg  cts_prev_ff;
	reg  rts_prev_ff;
	reg  tx_flag_ff;
	reg  ovr_flag_ff;
	reg  pause_flag_ff;
	reg  flow_flag_ff;
	wire enh;
	wire rx_cond;
	wire tx_cond;
	wire tx_set;
	wire flow_set;
	wire line_req;
	wire rx_req;
	wire tx_req;
	wire modem_req;
	wire pause_req;
	wire flow_req;

	assign enh      = feat[`FB_ENH];
	assign rx_cond  = fifo_en ? rx_at_trig : rx_nonempty;
	assign tx_cond  = fifo_en ? tx_below_trig : thr_empty;
	assign tx_set   = (tx_cond & ~tx_prev_ff) | (tx_cond & mask[`MB_TX] & ~mask_tx_prev_ff);
	assign flow_set = (feat[`FB_AUTO_RTS] & rts_out & ~rts_prev_ff)
	                | (feat[`FB_AUTO_CTS] & cts_in & ~cts_prev_ff);

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_prev_ff      <= 1'b0;
			mask_tx_prev_ff <= 1'b0;
			cts_prev_ff     <= 1'b0;
			rts_prev_ff     <= 1'b0;
			tx_flag_ff      <= 1'b0;
			ovr_flag_ff     <= 1'b0;
			pause_flag_ff   <= 1'b0;
			flow_flag_ff    <= 1'b0;
		end else begin
			tx_prev_ff      <= tx_cond;
			mask_tx_prev_ff <= mask[`MB_TX];
			cts_prev_ff     <= cts_in;
			rts_prev_ff     <= rts_out;
			// Set beats a clear arriving in the same cycle
			if (tx_set)
				tx_flag_ff <= 1'b1;
			else if (isr_rd | thr_wr | ~tx_cond)
				tx_flag_ff <= 1'b0;
			if (overrun_evt)
				ovr_flag_ff <= 1'b1;
			else if (lsr_rd)
				ovr_flag_ff <= 1'b0;
			if (pause_evt)
				pause_flag_ff <= 1'b1;
			else if (isr_rd | resume_evt)
				pause_flag_ff <= 1'b0;
			if (flow_set)
				flow_flag_ff <= 1'b1;
			else if (msr_rd)
				flow_flag_ff <= 1'b0;
		end
	end

	// ==============================================
	// Gating and priority
	assign line_req  = mask[`MB_LINE] & (ovr_flag_ff | (|head_err));
	assign rx_req    = mask[`MB_RX] & rx_cond;
	assign tx_req    = mask[`MB_TX] & tx_flag_ff;
	assign modem_req = mask[`MB_MODEM] & modem_any;
	assign pause_req = enh & mask[`MB_PAUSE] & pause_flag_ff;
	assign flow_req  = enh & mask[`MB_RTS] & mask[`MB_CTS] ? flow_flag_ff
	                 : enh & (mask[`MB_RTS] | mask[`MB_CTS]) & flow_flag_ff;
	assign irq_req   = line_req | rx_req | tx_req | modem_req | pause_req | flow_req;
	assign overrun_flag = ovr_flag_ff;

	always @* begin
		isr_val[7:6] = {2{fifo_en}};
		if (line_req)
			isr_val[5:0] = `SRC_LINE;
		else if (rx_req)
			isr_val[5:0] = `SRC_RX;
		else if (tx_req)
			isr_val[5:0] = `SRC_TX;
		else if (modem_req)
			isr_val[5:0] = `SRC_MODEM;
		else if (pause_req)
			isr_val[5:0] = `SRC_PAUSE;
		else if (flow_req)
			isr_val[5:0] = `SRC_FLOW;
		else
			isr_val[5:0] = `SRC_NONE;
	end

endmodule // chan_irq_qual
`default_nettype wire

// file: src/uart_irq_enable.v
/*
 * Four-channel interrupt mask, feature control and flow character
 * registers, line status assembly and the FIFO ready summary read.
 * Assumes the register port strobes are one-cycle pulses synchronous
 * to clk, and that FIFO, shifter and modem state come from the rest
 * of each channel.
 */
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_enable_defs.vh"

module uart_irq_enable #(
	parameter NCH = 4
) (
	input  wire           clk,
	input  wire           rst_b,
	input  wire [1:0]     bus_chan,
	input  wire [2:0]     bus_addr,
	input  wire           bus_rd,
	input  wire           bus_wr,
	input  wire [7:0]     bus_wdata,
	input  wire           summary_select_pin_n,
	input  wire [8*NCH-1:0] line_control_reg,
	input  wire [NCH-1:0] fifo_en,
	input  wire [NCH-1:0] rx_nonempty,
	input  wire [NCH-1:0] rx_at_trig,
	input  wire [NCH-1:0] thr_empty,
	input  wire [NCH-1:0] tsr_empty,
	input  wire [NCH-1:0] tx_below_trig,
	input  wire [NCH-1:0] overrun_evt,
	input  wire [3*NCH-1:0] head_err,
	input  wire [NCH-1:0] fifo_err_any,
	input  wire [NCH-1:0] modem_any,
	input  wire [NCH-1:0] pause_evt,
	input  wire [NCH-1:0] resume_evt,
	input  wire [NCH-1:0] rts_out,
	input  wire [NCH-1:0] cts_in,
	output reg  [7:0]     rdata_ff,
	output reg  [NCH-1:0] irq_ff,
	output reg  [NCH-1:0] sleep_en_ff,
	output wire [8*NCH-1:0] feature_ctl,
	output wire [8*NCH-1:0] resume_first,
	output wire [8*NCH-1:0] resume_second,
	output wire [8*NCH-1:0] pause_first,
	output wire [8*NCH-1:0] pause_second
);

	// ==============================================
	// Flattened per-channel views
	wire [8*NCH-1:0] mask_all;
	wire [8*NCH-1:0] isr_all;
	wire [8*NCH-1:0] lsr_all;
	wire [NCH-1:0]   irq_req;
	wire [NCH-1:0]   rx_ready_n;
	wire [NCH-1:0]   tx_ready_n;
	wire [7:0]       lcr_sel;
	wire             enh_sel;
	wire             std_sel;
	reg  [7:0]       nxt_rdata;

	assign lcr_sel = line_control_reg[{bus_chan, 3'b000} +: 8];
	assign enh_sel = (lcr_sel == `LCR_ENH_KEY);
	assign std_sel = ~lcr_sel[`LCR_DIV_BIT];

	// ==============================================
	// Channel registers
	genvar i;
	generate
		for (i = 0; i < NCH; i = i + 1) begin : chan
			reg  [7:0] mask_ff;
			reg  [7:0] feat_ff;
			reg  [7:0] res1_ff;
			reg  [7:0] res2_ff;
			reg  [7:0] pau1_ff;
			reg  [7:0] pau2_ff;
			reg  [7:0] nxt_mask;
			wire       here;
			wire       lcr_key;
			wire       lcr_std;
			wire       wr_std;
			wire       wr_enh;
			wire       isr_rd;
			wire       lsr_rd;
			wire       msr_rd;
			wire       thr_wr;
			wire       enh_on;

			assign here    = summary_select_pin_n & ({30'h0, bus_chan} == i);
			assign lcr_key = (line_control_reg[8*i +: 8] == `LCR_ENH_KEY);
			assign lcr_std = ~line_control_reg[8*i + `LCR_DIV_BIT];
			assign wr_std  = here & bus_wr & lcr_std;
			assign wr_enh  = here & bus_wr & lcr_key;
			assign isr_rd  = here & bus_rd & lcr_std & (bus_addr == `ADDR_SOURCE);
			assign lsr_rd  = here & bus_rd & lcr_std & (bus_addr == `ADDR_LSTAT);
			assign msr_rd  = here & bus_rd & lcr_std & (bus_addr == `ADDR_MSTAT);
			assign thr_wr  = wr_std & (bus_addr == `ADDR_HOLD);
			assign enh_on  = feat_ff[`FB_ENH];

			// Upper mask bits keep their value unless enhanced mode is on
			always @* begin
				nxt_mask[3:0] = bus_wdata[3:0];
				nxt_mask[7:4] = enh_on ? bus_wdata[7:4] : mask_ff[7:4];
			end

			always @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					mask_ff <= `MASK_RST;
					feat_ff <= `FEATURE_RST;
					res1_ff <= `CHAR_RST;
					res2_ff <= `CHAR_RST;
					pau1_ff <= `CHAR_RST;
					pau2_ff <= `CHAR_RST;
				end else begin
					if (wr_std & (bus_addr == `ADDR_MASK))
						mask_ff <= nxt_mask;
					if (wr_enh & (bus_addr == `ADDR_FEATURE))
						feat_ff <= bus_wdata;
					if (wr_enh & (bus_addr == `ADDR_RESUME1))
						res1_ff <= bus_wdata;
					if (wr_enh & (bus_addr == `ADDR_RESUME2))
						res2_ff <= bus_wdata;
					if (wr_enh & (bus_addr == `ADDR_PAUSE1))
						pau1_ff <= bus_wdata;
					if (wr_enh & (bus_addr == `ADDR_PAUSE2))
						pau2_ff <= bus_wdata;
				end
			end

			wire [7:0] isr_raw;
			wire       ovr_flag;

			chan_irq_qual u_qual (
				.clk           (clk),
				.rst_b         (rst_b),
				.mask          (mask_ff),
				.feat          (feat_ff),
				.fifo_en       (fifo_en[i]),
				.rx_nonempty   (rx_nonempty[i]),
				.rx_at_trig    (rx_at_trig[i]),
				.thr_empty     (thr_empty[i]),
				.tx_below_trig (tx_below_trig[i]),
				.overrun_evt   (overrun_evt[i]),
				.head_err      (head_err[3*i +: 3]),
				.modem_any     (modem_any[i]),
				.pause_evt     (pause_evt[i]),
				.resume_evt    (resume_evt[i]),
				.rts_out       (rts_out[i]),
				.cts_in        (cts_in[i]),
				.isr_rd        (isr_rd),
				.lsr_rd        (lsr_rd),
				.msr_rd        (msr_rd),
				.thr_wr        (thr_wr),
				.irq_req       (irq_req[i]),
				.isr_val       (isr_raw),
				.overrun_flag  (ovr_flag)
			);

			// Enhanced source bits read as zero without enhanced mode
			assign isr_all[8*i +: 8] = {isr_raw[7:6], isr_raw[5:4] & {2{enh_on}},
			                            isr_raw[3:0]};

			// Polled mode sees receiver and transmitter on separate bits
			assign lsr_all[8*i +: 8] = {
				fifo_err_any[i],
				thr_empty[i] & tsr_empty[i],
				thr_empty[i],
				head_err[3*i +: 3],
				ovr_flag,
				rx_nonempty[i]
			};

			assign rx_ready_n[i] = ~(fifo_en[i] ? rx_at_trig[i] : rx_nonempty[i]);
			assign tx_ready_n[i] = ~(fifo_en[i] ? tx_below_trig[i] : thr_empty[i]);

			assign mask_all[8*i +: 8]      = mask_ff;
			assign feature_ctl[8*i +: 8]   = feat_ff;
			assign resume_first[8*i +: 8]  = res1_ff;
			assign resume_second[8*i +: 8] = res2_ff;
			assign pause_first[8*i +: 8]   = pau1_ff;
			assign pause_second[8*i +: 8]  = pau2_ff;
		end
	endgenerate

	// ==============================================
	// Read path
	// Data are registered, so they appear one cycle after the read strobe
	always @* begin
		nxt_rdata = rdata_ff;
		if (bus_rd) begin
			nxt_rdata = 8'h00;
			if (!summary_select_pin_n)
				nxt_rdata = {rx_ready_n[3:0], tx_ready_n[3:0]};
			else if (enh_sel) begin
				case (bus_addr)
				`ADDR_FEATURE: nxt_rdata = feature_ctl[{bus_chan, 3'b000} +: 8];
				`ADDR_RESUME1: nxt_rdata = resume_first[{bus_chan, 3'b000} +: 8];
				`ADDR_RESUME2: nxt_rdata = resume_second[{bus_chan, 3'b000} +: 8];
				`ADDR_PAUSE1:  nxt_rdata = pause_first[{bus_chan, 3'b000} +: 8];
				`ADDR_PAUSE2:  nxt_rdata = pause_second[{bus_chan, 3'b000} +: 8];
				default:       nxt_rdata = 8'h00;
				endcase
			end else if (std_sel) begin
				case (bus_addr)
				`ADDR_MASK:   nxt_rdata = mask_all[{bus_chan, 3'b000} +: 8];
				`ADDR_SOURCE: nxt_rdata = isr_all[{bus_chan, 3'b000} +: 8];
				`ADDR_LSTAT:  nxt_rdata = lsr_all[{bus_chan, 3'b000} +: 8];
				default:      nxt_rdata = 8'h00;
				endcase
			end
		end
	end

	// ==============================================
	// Output flops
	integer k;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_ff    <= 8'h00;
			irq_ff      <= {NCH{1'b0}};
			sleep_en_ff <= {NCH{1'b0}};
		end else begin
			rdata_ff <= nxt_rdata;
			irq_ff   <= irq_req;
			for (k = 0; k < NCH; k = k + 1) begin
				sleep_en_ff[k] <= mask_all[8*k + `MB_SLEEP] & feature_ctl[8*k + `FB_ENH];
			end
		end
	end

endmodule // uart_irq_enable
`default_nettype wire

// file: testbench/uart_irq_enable_props.sv
/* Port-level checker for the mask, feature and summary block.
   Bound to uart_irq_enable; one clock, asynchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module uart_irq_enable_props #(
	parameter NCH = 4
) (
	input wire logic             clk,
	input wire logic             rst_b,
	input wire logic [1:0]       bus_chan,
	input wire logic [2:0]       bus_addr,
	input wire logic             bus_rd,
	input wire logic             bus_wr,
	input wire logic [7:0]       bus_wdata,
	input wire logic             summary_select_pin_n,
	input wire logic [8*NCH-1:0] line_control_reg,
	input wire logic [NCH-1:0]   fifo_en,
	input wire logic [NCH-1:0]   rx_nonempty,
	input wire logic [NCH-1:0]   rx_at_trig,
	input wire logic [NCH-1:0]   thr_empty,
	input wire logic [NCH-1:0]   tsr_empty,
	input wire logic [NCH-1:0]   tx_below_trig,
	input wire logic [NCH-1:0]   overrun_evt,
	input wire logic [3*NCH-1:0] head_err,
	input wire logic [NCH-1:0]   fifo_err_any,
	input wire logic [7:0]       rdata_ff,
	input wire logic [NCH-1:0]   irq_ff,
	input wire logic [NCH-1:0]   sleep_en_ff,
	input wire logic [8*NCH-1:0] feature_ctl,
	input wire logic [8*NCH-1:0] resume_first,
	input wire logic [8*NCH-1:0] resume_second,
	input wire logic [8*NCH-1:0] pause_first,
	input wire logic [8*NCH-1:0] pause_second
);
	// ====================
	// Helpers
	wire       sel_n = summary_select_pin_n;
	wire [7:0] lcr_sel = line_control_reg[8*bus_chan +: 8];
	wire       lsr_rd = bus_rd && sel_n && bus_addr == 3'h5 && !lcr_sel[7];
	// Overrun bit left out: it is sticky inside the block
	wire [7:0] lsr_exp = {fifo_err_any[bus_chan], thr_empty[bus_chan] & tsr_empty[bus_chan],
		thr_empty[bus_chan], head_err[3*bus_chan +: 3], 1'b0, rx_nonempty[bus_chan]};
	logic [7:0] sum_exp;
	logic [7:0] enh_exp;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			sum_exp[4+i] = ~(fifo_en[i] ? rx_at_trig[i] : rx_nonempty[i]);
			sum_exp[i] = ~(fifo_en[i] ? tx_below_trig[i] : thr_empty[i]);
		end
		case (bus_addr)
			3'h2: enh_exp = feature_ctl[8*bus_chan +: 8];
			3'h4: enh_exp = resume_first[8*bus_chan +: 8];
			3'h5: enh_exp = resume_second[8*bus_chan +: 8];
			3'h6: enh_exp = pause_first[8*bus_chan +: 8];
			default: enh_exp = pause_second[8*bus_chan +: 8];
		endcase
	end
	// ====================
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_summary; bus_rd && !sel_n |=> rdata_ff == $past(sum_exp); endproperty
	a_summary: assert property (p_summary) else $error("summary read wrong");
	property p_status; lsr_rd |=> (rdata_ff & 8'hFD) == $past(lsr_exp); endproperty
	a_status: assert property (p_status) else $error("status read wrong");
	property p_overrun;
		overrun_evt[0] && !bus_rd ##1 !bus_rd ##1 lsr_rd && bus_chan == 2'h0 |=> rdata_ff[1];
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not shown");
	property p_enh_read;
		bus_rd && sel_n && lcr_sel == 8'hBF && bus_addr inside {3'h2, [3'h4:3'h7]}
			|=> rdata_ff == $past(enh_exp);
	endproperty
	a_enh_read: assert property (p_enh_read) else $error("keyed read wrong");
	property p_enh_write;
		bus_wr && sel_n && lcr_sel == 8'hBF && bus_addr == 3'h4 && bus_chan == 2'h0
			|=> resume_first[7:0] == $past(bus_wdata);
	endproperty
	a_enh_write: assert property (p_enh_write) else $error("keyed write lost");
	property p_enh_block;
		bus_wr && (!sel_n || lcr_sel != 8'hBF) |=> $stable(feature_ctl) && $stable(resume_first)
			&& $stable(resume_second) && $stable(pause_first) && $stable(pause_second);
	endproperty
	a_enh_block: assert property (p_enh_block) else $error("unkeyed write landed");
	property p_chan;
		bus_wr && bus_chan != 2'h0 |=> $stable(feature_ctl[7:0]) && $stable(resume_first[7:0]);
	endproperty
	a_chan: assert property (p_chan) else $error("channel A disturbed");
	property p_sleep; sleep_en_ff[0] |-> $past(feature_ctl[4]); endproperty
	a_sleep: assert property (p_sleep) else $error("sleep without enhanced");
	c_summary: cover property (bus_rd && !sel_n);
	c_sleep: cover property ($rose(sleep_en_ff[0]));
	c_irq: cover property ($rose(irq_ff[0]));
endmodule // uart_irq_enable_props
bind uart_irq_enable uart_irq_enable_props #(.NCH(NCH)) u_props (.*);
`default_nettype wire

// file: testbench/host_bus.sv
/* Host processor model on the register port.
   Strobes last one cycle; read data is taken after the sampling edge. */
`timescale 1ns/1ps
`default_nettype none
module host_bus (
	input  wire logic       clk,
	input  wire logic [7:0] rdata_ff,
	output var  logic [1:0] bus_chan = 2'h0,
	output var  logic [2:0] bus_addr = 3'h0,
	output var  logic       bus_rd = 1'b0,
	output var  logic       bus_wr = 1'b0,
	output var  logic [7:0] bus_wdata = 8'h00
);
	task automatic wr(input logic [1:0] ch, input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_chan <= ch;
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] ch, input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		bus_chan <= ch;
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1 d = rdata_ff;
	endtask
endmodule // host_bus
`default_nettype wire

// file: testbench/uart_irq_enable_tb.sv
/* Self-checking bench for the mask, feature and summary block.
   Uses host_bus for register cycles and a bench register model. */
`timescale 1ns/1ps
`default_nettype none
module uart_irq_enable_tb;
	logic clk = 1'b0, rst_b = 1'b0, summary_select_pin_n = 1'b1;
	logic [31:0] line_control_reg = 32'h03030303;
	logic [3:0] fifo_en = 4'h0, rx_nonempty = 4'h0, rx_at_trig = 4'h0, thr_empty = 4'h0;
	logic [3:0] tsr_empty = 4'h0, tx_below_trig = 4'h0, overrun_evt = 4'h0, fifo_err_any = 4'h0;
	logic [3:0] modem_any = 4'h0, pause_evt = 4'h0, resume_evt = 4'h0, rts_out = 4'h0, cts_in = 4'h0;
	logic [11:0] head_err = 12'h000;
	wire [1:0] bus_chan;
	wire [2:0] bus_addr;
	wire bus_rd, bus_wr;
	wire [7:0] bus_wdata, rdata_ff;
	wire [3:0] irq_ff, sleep_en_ff;
	wire [31:0] feature_ctl, resume_first, resume_second, pause_first, pause_second;
	int err_count = 0, checks = 0;
	int adr [5] = '{2, 4, 5, 6, 7};
	logic [7:0] mask_m [4];
	logic [7:0] char_m [4][8];
	logic [7:0] v;

	uart_irq_enable #(.NCH(4)) i_dut (.*);
	host_bus u_host (.*);
	always #50 clk = ~clk;

	// ====================
	// Tasks
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic chk_irq(logic exp);
		checks++;
		if (irq_ff[0] !== exp) begin
			err_count++;
			$display("BAD irq exp %b got %b", exp, irq_ff[0]);
		end
	endtask
	task automatic get(int ch, int a, logic [7:0] exp, string what);
		u_host.rd(ch[1:0], a[2:0], v);
		chk(what, exp, v);
	endtask
	// Model follows the key and enhanced-enable gating
	task automatic put(int ch, int a, logic [7:0] d);
		logic [7:0] l;
		u_host.wr(ch[1:0], a[2:0], d);
		l = line_control_reg[8*ch +: 8];
		if (!summary_select_pin_n)
			return;
		if (l == 8'hBF && a >= 2 && a != 3)
			char_m[ch][a] = d;
		else if (a == 1 && !l[7])
			mask_m[ch] = char_m[ch][2][4] ? d : {mask_m[ch][7:4], d[3:0]};
	endtask
	task automatic set_lcr(logic [7:0] x);
		@(posedge clk);
		line_control_reg <= {4{x}};
	endtask
	task automatic settle(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic irq_case(logic [7:0] m, logic [5:0] code);
		put(0, 1, m);
		settle(3);
		chk_irq(1'b1);
		get(0, 2, {{2{fifo_en[0]}}, code}, "source");
	endtask
	function automatic logic [7:0] sum_e();
		for (int i = 0; i < 4; i++) begin
			sum_e[4+i] = ~(fifo_en[i] ? rx_at_trig[i] : rx_nonempty[i]);
			sum_e[i] = ~(fifo_en[i] ? tx_below_trig[i] : thr_empty[i]);
		end
	endfunction
	task automatic finish_test;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ====================
	// Sequence
	initial begin
		void'($urandom(77048));
		foreach (char_m[c, a])
			char_m[c][a] = 8'h00;
		foreach (mask_m[c])
			mask_m[c] = 8'h00;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		for (int c = 0; c < 4; c++)
			get(c, 1, mask_m[c], "mask");
		set_lcr(8'hBF);
		foreach (char_m[c, a])
			if (a inside {2, [4:7]})
				put(c, a, 8'($urandom));
		for (int c = 0; c < 4; c++)
			foreach (adr[i])
				get(c, adr[i], char_m[c][adr[i]], "keyed");
		set_lcr(8'h03);
		put(1, 4, 8'h5A);
		#1;
		chk("resume", char_m[1][4], resume_first[15:8]);
		@(posedge clk);
		summary_select_pin_n <= 1'b0;
		put(2, 2, 8'hA5);
		repeat (4) begin
			@(posedge clk);
			{fifo_en, rx_nonempty, rx_at_trig, thr_empty} <= 16'($urandom);
			tx_below_trig <= 4'($urandom);
			@(posedge clk);
			get($urandom % 4, $urandom % 8, sum_e(), "summary");
		end
		@(posedge clk);
		summary_select_pin_n <= 1'b1;
		{fifo_en, rx_nonempty, rx_at_trig, thr_empty, tx_below_trig} <= 20'h00000;
		set_lcr(8'hBF);
		put(0, 2, 8'h00);
		set_lcr(8'h03);
		put(0, 1, 8'hFF);
		get(0, 1, mask_m[0], "mask low");
		chk("sleep", 8'h00, {7'h0, sleep_en_ff[0]});
		set_lcr(8'hBF);
		put(0, 2, 8'h10);
		set_lcr(8'h03);
		put(0, 1, 8'hF0);
		get(0, 1, mask_m[0], "mask high");
		chk("sleep", 8'h01, {7'h0, sleep_en_ff[0]});
		@(posedge clk);
		thr_empty[0] <= 1'b1;
		// Drop the empty-edge flag so only the mask rise can raise it
		get(0, 2, 8'h01, "source");
		irq_case(8'h02, 6'h02);
		settle(2);
		chk_irq(1'b0);
		@(posedge clk);
		thr_empty[0] <= 1'b0;
		rx_nonempty[0] <= 1'b1;
		irq_case(8'h01, 6'h04);
		@(posedge clk);
		rx_nonempty[0] <= 1'b0;
		fifo_en[0] <= 1'b1;
		rx_at_trig[0] <= 1'b1;
		irq_case(8'h01, 6'h04);
		@(posedge clk);
		rx_at_trig[0] <= 1'b0;
		settle(2);
		chk_irq(1'b0);
		@(posedge clk);
		head_err[0] <= 1'b1;
		irq_case(8'h04, 6'h06);
		@(posedge clk);
		head_err[0] <= 1'b0;
		overrun_evt[0] <= 1'b1;
		@(posedge clk);
		overrun_evt[0] <= 1'b0;
		get(0, 5, 8'h02, "status");
		put(0, 1, 8'h00);
		@(posedge clk);
		{rx_nonempty[0], thr_empty[0], tsr_empty[0], fifo_err_any[0]} <= 4'hF;
		settle(3);
		chk_irq(1'b0);
		get(0, 5, 8'hE1, "status");
		@(posedge clk);
		{rx_nonempty[0], thr_empty[0], tsr_empty[0], fifo_err_any[0]} <= 4'h0;
		modem_any[0] <= 1'b1;
		irq_case(8'h08, 6'h00);
		@(posedge clk);
		modem_any[0] <= 1'b0;
		pause_evt[0] <= 1'b1;
		@(posedge clk);
		pause_evt[0] <= 1'b0;
		irq_case(8'h20, 6'h10);
		@(posedge clk);
		pause_evt[0] <= 1'b1;
		@(posedge clk);
		pause_evt[0] <= 1'b0;
		settle(2);
		chk_irq(1'b1);
		@(posedge clk);
		resume_evt[0] <= 1'b1;
		@(posedge clk);
		resume_evt[0] <= 1'b0;
		settle(2);
		chk_irq(1'b0);
		set_lcr(8'hBF);
		put(0, 2, 8'h90);
		set_lcr(8'h03);
		@(posedge clk);
		cts_in[0] <= 1'b1;
		irq_case(8'h80, 6'h20);
		u_host.rd(2'h0, 3'h6, v);
		settle(2);
		chk_irq(1'b0);
		set_lcr(8'hBF);
		put(0, 2, 8'h50);
		set_lcr(8'h03);
		@(posedge clk);
		rts_out[0] <= 1'b1;
		irq_case(8'h40, 6'h20);
		finish_test;
	end
	// Sequence needs well under 1000 cycles
	initial begin
		repeat (4000) @(posedge clk);
		err_count++;
		$display("BAD watchdog exp done got timeout");
		finish_test;
	end
endmodule // uart_irq_enable_tb
`default_nettype wire
